//--- rtl/spwd_defines.svh
`ifndef SPWD_DEFINES_SVH
`define SPWD_DEFINES_SVH

// Opcodes
`define SPWD_OP_UNLOCK      8'h06
`define SPWD_OP_LOCK        8'h04
`define SPWD_OP_WRITE       8'h01
`define SPWD_OP_READ        8'h05
`define SPWD_OP_TRIP_A      8'h03
`define SPWD_OP_TRIP_B      8'h02
`define SPWD_TRIP_ADDR      8'h00
`define SPWD_TRIP_SET_DATA  8'h01
`define SPWD_TRIP_RST_DATA  8'h03

// Register layout
`define SPWD_SEL_HI_POS     4
`define SPWD_SEL_LO_POS     3
`define SPWD_SEL_RESET      2'h0
`define SPWD_SEL_OFF        2'h3

// Frame lengths in serial clocks
`define SPWD_WRITE_BITS     6'd16
`define SPWD_TRIP_BITS      6'd24

// Timing
`define SPWD_CLK_MHZ        100
`define SPWD_TO_00_MS       1400
`define SPWD_TO_01_MS       600
`define SPWD_TO_10_MS       200
`define SPWD_PURST_MS       200
`define SPWD_MS_CYCLES(ms)  ((ms) * 1000 * `SPWD_CLK_MHZ)

`endif

//--- rtl/spwd_pkg.sv
package spwd_pkg;
	typedef enum logic [3:0] {
		SPWD_IDLE  = 4'b0001,
		SPWD_OPC   = 4'b0010,
		SPWD_DATA  = 4'b0100,
		SPWD_DONE  = 4'b1000
	} spwd_state_e;

	typedef struct packed {
		logic sclk;
		logic sdi;
		logic sel_n;
	} spwd_pins_s;

	typedef struct packed {
		logic set_req;
		logic rst_req;
	} spwd_trip_s;
endpackage

//--- rtl/spwd_sync.sv
`timescale 1ns/1ps
module spwd_sync (
	// Clock
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  wire logic                 ce,
	// Pins
	input  wire spwd_pkg::spwd_pins_s pin_in,
	// Filtered
	output spwd_pkg::spwd_pins_s      pin_out
);
	import spwd_pkg::*;

	spwd_pins_s s1_ff, s2_ff, s3_ff, out_ff;
	spwd_pins_s nxt_out;

	// Level changes once the second and third stages agree
	generate
		for (genvar i = 0; i < 3; i++) begin : g_bit
			always_comb begin
				nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s1_ff  <= 3'b001;
			s2_ff  <= 3'b001;
			s3_ff  <= 3'b001;
			out_ff <= 3'b001;
		end else if (ce) begin
			s1_ff  <= pin_in;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			out_ff <= nxt_out;
		end
	end

	assign pin_out = out_ff;
endmodule // spwd_sync

//--- rtl/spwd_timer.sv
`timescale 1ns/1ps
`include "spwd_defines.svh"
module spwd_timer (
	// Clock
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       ce,
	// Control
	input  wire logic       restart,
	input  wire logic       enable,
	input  wire logic [31:0] limit,
	// Status
	output logic            expired
);
	import spwd_pkg::*;

	logic [31:0] cnt_ff, nxt_cnt;
	logic        exp_ff, nxt_exp;

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_exp = exp_ff;
		if (restart || !enable) begin
			nxt_cnt = 32'h0;
			nxt_exp = 1'b0;
		end else if (cnt_ff >= limit - 32'h1) begin
			nxt_exp = 1'b1;
		end else begin
			nxt_cnt = cnt_ff + 32'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_ff <= 32'h0;
			exp_ff <= 1'b0;
		end else if (ce) begin
			cnt_ff <= nxt_cnt;
			exp_ff <= nxt_exp;
		end
	end

	assign expired = exp_ff;
endmodule // spwd_timer

//--- rtl/spwd_top.sv
`timescale 1ns/1ps
`include "spwd_defines.svh"
// Operation
// RULE1 - Every falling edge on select/kick restarts the watchdog count.
// RULE2 - Select bits 00=1.4s, 01=600ms, 10=200ms, 11=watchdog off.
// RULE3 - Host writes select bits at data bits 4 and 3, others zero.
// RULE4 - Read returns select bits in place, reserved bits zero.
// RULE5 - Timeout write accepted only while change latch is set.
// RULE6 - Opcode 06h sets change latch, 04h clears it.
// RULE7 - Opcode 01h then data byte; store its bits 4 and 3.
// RULE8 - Opcode 05h shifts register out on serial output.
// RULE9 - Change latch cleared at power-up and after a completed write.
// RULE10 - Read during nonvolatile write returns constant high.
// RULE11 - Sample on rising clock, shift out on falling, MSB first.
// RULE12 - Serial clock may halt anywhere; transfer resumes at same bit.
// RULE13 - After power-up, standby, output off until select falls.
// RULE14 - Timeout change applied only if select rises at correct count.
// RULE15 - Frames 03 00 01 then 02 00 01 with enable start trip set.
// RULE16 - Frames 03 00 01 then 02 00 03 with enable start trip reset.
// RULE17 - Reset output active when watchdog reaches selected limit.
// RULE18 - Reset output held active for power-up interval.
// RULE19 - Select bits retained in nonvolatile storage across power cycles.
// RULE20 - Reset stays active 200ms after supply returns above trip.
// RULE21 - Select high deselects, output off, serial clock ignored.
// RULE22 - Write frame valid only at exactly sixteen clocks.
// RULE23 - Trip sequence pulses program request; busy until analog done.
module spwd_top #(
	parameter int unsigned PURST_CYCLES = `SPWD_MS_CYCLES(`SPWD_PURST_MS),
	parameter int unsigned TO_00_CYCLES = `SPWD_MS_CYCLES(`SPWD_TO_00_MS),
	parameter int unsigned TO_01_CYCLES = `SPWD_MS_CYCLES(`SPWD_TO_01_MS),
	parameter int unsigned TO_10_CYCLES = `SPWD_MS_CYCLES(`SPWD_TO_10_MS)
) (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  wire logic                 ce,
	// Serial pins
	input  wire spwd_pkg::spwd_pins_s pins,
	output logic                      sdo_out,
	output logic                      sdo_oe,
	// Supply and programming
	input  wire logic                 supply_low,
	input  wire logic                 trip_program_enable_pin,
	input  wire logic                 trip_prog_done,
	output spwd_pkg::spwd_trip_s      trip_req,
	// Nonvolatile store
	input  wire logic [1:0]           nv_sel_in,
	input  wire logic                 nv_write_done,
	output logic                      nv_write_req,
	output logic [1:0]                nv_sel_out,
	// Reset output, open drain
	output logic                      reset_n_out,
	output logic                      reset_n_oe
);
	import spwd_pkg::*;

	spwd_pins_s  pin_s;
	logic        pin_vld_ff, nxt_pin_vld;
	spwd_pins_s  prev_ff;
	logic        sel_fall, sel_rise, sck_rise, sck_fall;

	spwd_sync u_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.pin_in  (pins),
		.pin_out (pin_s)
	);

	// ****************************************
	// Edge detection
	// ****************************************
	always_comb begin
		nxt_pin_vld = 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prev_ff    <= 3'b001;
			pin_vld_ff <= 1'b0;
		end else if (ce) begin
			prev_ff    <= pin_s;
			pin_vld_ff <= nxt_pin_vld;
		end
	end

	assign sel_fall = pin_vld_ff && prev_ff.sel_n && !pin_s.sel_n;
	assign sel_rise = pin_vld_ff && !prev_ff.sel_n && pin_s.sel_n;
	assign sck_rise = !pin_s.sel_n && !prev_ff.sclk && pin_s.sclk; // [RULE11] [RULE21]
	assign sck_fall = !pin_s.sel_n && prev_ff.sclk && !pin_s.sclk;

	// ****************************************
	// Serial frame engine
	// ****************************************
	spwd_state_e st_ff, nxt_st;
	logic [5:0]  bits_ff, nxt_bits;
	logic [7:0]  sh_ff, nxt_sh;
	logic [7:0]  opc_ff, nxt_opc;
	logic [7:0]  b1_ff, nxt_b1;
	logic [7:0]  b2_ff, nxt_b2;
	logic [7:0]  tx_ff, nxt_tx;
	logic        rd_ff, nxt_rd;
	logic        so_ff, nxt_so;
	logic        oe_ff, nxt_oe;
	logic        latch_ff, nxt_latch;
	logic        trip_a_ff, nxt_trip_a;
	logic        busy_ff, nxt_busy;
	logic        nvreq_ff, nxt_nvreq;
	logic [1:0]  sel_ff, nxt_sel;
	logic [1:0]  newsel_ff, nxt_newsel;
	logic        load_ff, nxt_load;
	spwd_trip_s  treq_ff, nxt_treq;
	logic        tbusy_ff, nxt_tbusy;
	logic        wr_ok, tset_ok, treset_ok;
	logic [7:0]  rx_byte;

	assign rx_byte   = {sh_ff[6:0], pin_s.sdi};
	assign wr_ok     = (opc_ff == `SPWD_OP_WRITE) && (bits_ff == `SPWD_WRITE_BITS) && latch_ff
	                   && !busy_ff; // [RULE5] [RULE14] [RULE22]
	assign tset_ok   = trip_a_ff && trip_program_enable_pin && (bits_ff == `SPWD_TRIP_BITS)
	                   && (opc_ff == `SPWD_OP_TRIP_B) && (b1_ff == `SPWD_TRIP_ADDR)
	                   && (b2_ff == `SPWD_TRIP_SET_DATA); // [RULE15]
	assign treset_ok = trip_a_ff && trip_program_enable_pin && (bits_ff == `SPWD_TRIP_BITS)
	                   && (opc_ff == `SPWD_OP_TRIP_B) && (b1_ff == `SPWD_TRIP_ADDR)
	                   && (b2_ff == `SPWD_TRIP_RST_DATA); // [RULE16]

	always_comb begin
		nxt_st     = st_ff;
		nxt_bits   = bits_ff;
		nxt_sh     = sh_ff;
		nxt_opc    = opc_ff;
		nxt_b1     = b1_ff;
		nxt_b2     = b2_ff;
		nxt_tx     = tx_ff;
		nxt_rd     = rd_ff;
		nxt_so     = so_ff;
		nxt_oe     = oe_ff;
		nxt_latch  = latch_ff;
		nxt_trip_a = trip_a_ff;
		nxt_busy   = busy_ff;
		nxt_nvreq  = 1'b0;
		nxt_sel    = sel_ff;
		nxt_newsel = newsel_ff;
		nxt_load   = 1'b0;
		nxt_treq   = '0;
		nxt_tbusy  = tbusy_ff;
		if (load_ff) begin
			nxt_sel = nv_sel_in; // [RULE19]
		end
		if (busy_ff && nv_write_done) begin
			nxt_busy  = 1'b0;
			nxt_sel   = newsel_ff;
			nxt_latch = 1'b0; // [RULE9]
		end
		if (tbusy_ff && trip_prog_done) begin
			nxt_tbusy = 1'b0; // [RULE23]
		end
		case (st_ff)
			SPWD_IDLE: begin
				if (sel_fall) begin
					nxt_st    = SPWD_OPC; // [RULE13]
					nxt_bits  = 6'd0;
				end
			end
			SPWD_OPC, SPWD_DATA: begin
				// Halted clock simply leaves bit count in place [RULE12]
				if (sck_rise) begin
					nxt_sh   = rx_byte;
					nxt_bits = bits_ff + 6'd1;
					if (bits_ff[2:0] == 3'd7) begin
						case (bits_ff[5:3])
							3'd0: begin
								nxt_opc = rx_byte;
								nxt_st  = SPWD_DATA;
								if (rx_byte == `SPWD_OP_UNLOCK) begin
									nxt_latch = 1'b1; // [RULE6]
								end else if (rx_byte == `SPWD_OP_LOCK) begin
									nxt_latch = 1'b0; // [RULE6]
								end else if (rx_byte == `SPWD_OP_READ) begin
									nxt_rd = 1'b1; // [RULE8]
									// Busy answers all ones [RULE10]
									nxt_tx = (busy_ff || tbusy_ff) ? 8'hFF :
									         {3'b000, sel_ff, 3'b000}; // [RULE4]
								end
							end
							3'd1: nxt_b1 = rx_byte; // [RULE7]
							3'd2: nxt_b2 = rx_byte;
							default: nxt_b2 = b2_ff;
						endcase
					end
				end
				if (sck_fall && rd_ff) begin
					nxt_oe = 1'b1;
					nxt_so = tx_ff[7]; // [RULE11]
					nxt_tx = {tx_ff[6:0], tx_ff[7]};
				end
				if (sel_rise) begin
					nxt_st = SPWD_DONE;
				end
			end
			SPWD_DONE: begin
				nxt_rd     = 1'b0;
				nxt_oe     = 1'b0; // [RULE21]
				nxt_st     = SPWD_IDLE;
				nxt_trip_a = (opc_ff == `SPWD_OP_TRIP_A) && (bits_ff == `SPWD_TRIP_BITS)
				             && (b1_ff == `SPWD_TRIP_ADDR) && (b2_ff == `SPWD_TRIP_SET_DATA);
				if (wr_ok) begin
					nxt_newsel = {b1_ff[`SPWD_SEL_HI_POS], b1_ff[`SPWD_SEL_LO_POS]}; // [RULE3] [RULE7]
					nxt_busy   = 1'b1;
					nxt_nvreq  = 1'b1;
				end
				if (tset_ok || treset_ok) begin
					nxt_treq.set_req = tset_ok;
					nxt_treq.rst_req = treset_ok;
					nxt_tbusy        = 1'b1; // [RULE23]
				end
			end
			default: nxt_st = SPWD_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_ff     <= SPWD_IDLE;
			bits_ff   <= 6'd0;
			sh_ff     <= 8'h00;
			opc_ff    <= 8'h00;
			b1_ff     <= 8'h00;
			b2_ff     <= 8'h00;
			tx_ff     <= 8'h00;
			rd_ff     <= 1'b0;
			so_ff     <= 1'b0;
			oe_ff     <= 1'b0; // [RULE13]
			latch_ff  <= 1'b0; // [RULE9]
			trip_a_ff <= 1'b0;
			busy_ff   <= 1'b0;
			nvreq_ff  <= 1'b0;
			sel_ff    <= `SPWD_SEL_RESET;
			newsel_ff <= `SPWD_SEL_RESET;
			load_ff   <= 1'b1;
			treq_ff   <= '0;
			tbusy_ff  <= 1'b0;
		end else if (ce) begin
			st_ff     <= nxt_st;
			bits_ff   <= nxt_bits;
			sh_ff     <= nxt_sh;
			opc_ff    <= nxt_opc;
			b1_ff     <= nxt_b1;
			b2_ff     <= nxt_b2;
			tx_ff     <= nxt_tx;
			rd_ff     <= nxt_rd;
			so_ff     <= nxt_so;
			oe_ff     <= nxt_oe;
			latch_ff  <= nxt_latch;
			trip_a_ff <= nxt_trip_a;
			busy_ff   <= nxt_busy;
			nvreq_ff  <= nxt_nvreq;
			sel_ff    <= nxt_sel;
			newsel_ff <= nxt_newsel;
			load_ff   <= nxt_load;
			treq_ff   <= nxt_treq;
			tbusy_ff  <= nxt_tbusy;
		end
	end

	// ****************************************
	// Watchdog and reset output
	// ****************************************
	logic [31:0] limit;
	logic        wd_exp;
	logic        por_done_ff, nxt_por_done;
	logic [31:0] por_cnt_ff, nxt_por_cnt;
	logic        rst_act_ff, nxt_rst_act;

	always_comb begin
		case (sel_ff) // [RULE2]
			2'h0:    limit = TO_00_CYCLES;
			2'h1:    limit = TO_01_CYCLES;
			2'h2:    limit = TO_10_CYCLES;
			default: limit = TO_00_CYCLES;
		endcase
	end

	spwd_timer u_timer (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.restart (sel_fall), // [RULE1]
		.enable  (sel_ff != `SPWD_SEL_OFF && por_done_ff),
		.limit   (limit),
		.expired (wd_exp)
	);

	always_comb begin
		nxt_por_cnt  = por_cnt_ff;
		nxt_por_done = por_done_ff;
		if (supply_low) begin
			nxt_por_cnt  = 32'h0;
			nxt_por_done = 1'b0; // [RULE20]
		end else if (!por_done_ff) begin
			if (por_cnt_ff >= PURST_CYCLES - 32'h1) begin
				nxt_por_done = 1'b1; // [RULE18]
			end else begin
				nxt_por_cnt = por_cnt_ff + 32'h1;
			end
		end
		nxt_rst_act = !por_done_ff || supply_low || wd_exp; // [RULE17]
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			por_cnt_ff  <= 32'h0;
			por_done_ff <= 1'b0;
			rst_act_ff  <= 1'b1;
		end else if (ce) begin
			por_cnt_ff  <= nxt_por_cnt;
			por_done_ff <= nxt_por_done;
			rst_act_ff  <= nxt_rst_act;
		end
	end

	assign sdo_out      = so_ff;
	assign sdo_oe       = oe_ff;
	assign trip_req     = treq_ff;
	assign nv_write_req = nvreq_ff;
	assign nv_sel_out   = newsel_ff;
	assign reset_n_out  = 1'b0;
	assign reset_n_oe   = rst_act_ff;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst || !ce);

	sequence unlock_seq;
		st_ff == SPWD_OPC && sck_rise && bits_ff == 6'd7 && rx_byte == `SPWD_OP_UNLOCK;
	endsequence

	latch_set_a: assert property (unlock_seq |=> latch_ff) // [RULE6]
		else $error("Unlock did not set latch");
	latch_clr_a: assert property (busy_ff && nv_write_done && !(st_ff == SPWD_OPC && sck_rise && bits_ff == 6'd7
		&& rx_byte == `SPWD_OP_UNLOCK) |=> !latch_ff) // [RULE9]
		else $error("Latch not cleared after write");
	write_gate_a: assert property ($rose(nvreq_ff) |-> $past(latch_ff)) // [RULE5]
		else $error("Write without latch");
	write_count_a: assert property ($rose(nvreq_ff) |-> $past(bits_ff) == `SPWD_WRITE_BITS) // [RULE22]
		else $error("Write at wrong clock count");
	oe_idle_a: assert property (st_ff == SPWD_IDLE |-> !oe_ff) // [RULE21]
		else $error("Output driven while deselected");
	busy_read_a: assert property (rd_ff && busy_ff && sck_fall ##1 1'b1 |-> so_ff) // [RULE10]
		else $error("Busy read not high");
	wd_reset_a: assert property (wd_exp |=> reset_n_oe) // [RULE17]
		else $error("Expiry without reset");
	por_hold_a: assert property (!por_done_ff |=> reset_n_oe) // [RULE18]
		else $error("Reset released early");
	kick_a: assert property (sel_fall |=> ##1 !wd_exp) // [RULE1]
		else $error("Kick did not restart timer");
	trip_a: assert property (tset_ok && st_ff == SPWD_DONE |=> trip_req.set_req && tbusy_ff) // [RULE15]
		else $error("Trip set not requested");
endmodule // spwd_top

//--- testbench/spwd_host.sv
`timescale 1ns/1ps
module spwd_host (
	// Clock
	input  wire logic            sys_clk,
	// Serial pins
	output spwd_pkg::spwd_pins_s pins,
	input  wire logic            sdo_out,
	input  wire logic            sdo_oe
);
	import spwd_pkg::*;
	int stall_bit = -1;

	initial pins = '{1'b0, 1'b1, 1'b1};

	// ***
	// Mode 0 frames
	// ***
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic xfer(input logic [23:0] data, input int nbits, output logic [7:0] rx);
		rx = 8'h00;
		pins.sel_n <= 1'b0;
		for (int i = 0; i < nbits; i++) begin
			wt(1);
			pins.sdi <= data[nbits-1-i];
			wt(6);
			if (i >= 8 && i < 16)
				rx = {rx[6:0], sdo_oe ? sdo_out : 1'bx};
			pins.sclk <= 1'b1;
			wt(6);
			if (i == stall_bit)
				wt(300);
			pins.sclk <= 1'b0;
		end
		wt(7);
		pins.sel_n <= 1'b1;
		pins.sdi <= ~pins.sdi;
		wt(10);
	endtask

	task automatic kick();
		logic [7:0] rx;
		xfer(24'h0, 0, rx);
	endtask

	// Clock toggles while deselected
	task automatic idle_clocks();
		repeat (4) begin
			wt(6);
			pins.sclk <= ~pins.sclk;
		end
	endtask
endmodule // spwd_host

//--- testbench/spi_watchdog_supervisor_tb.sv
`timescale 1ns/1ps
module spi_watchdog_supervisor_tb;
	import spwd_pkg::*;
	localparam int unsigned PUR = 100;
	localparam int unsigned T00 = 2800;
	localparam int unsigned T01 = 1200;
	localparam int unsigned T10 = 400;
	typedef struct {logic [1:0] sel; logic [7:0] rd; int lim;} spwd_row_s;
	spwd_row_s  rows [4] = '{'{2'h0, 8'h00, T00}, '{2'h1, 8'h08, T01}, '{2'h2, 8'h10, T10}, '{2'h3, 8'h18, 0}};
	logic       sys_clk = 1'b0;
	logic       rst = 1'b1;
	spwd_pins_s pins;
	logic       sdo_out, sdo_oe, nv_req, reset_n_out, reset_n_oe;
	logic       supply_low = 1'b0;
	logic       ce = 1'b1;
	logic       tpe = 1'b0;
	logic       trip_done = 1'b0;
	logic       nv_done = 1'b0;
	spwd_trip_s trip_req;
	logic [1:0] nv_sel = 2'h1;
	logic [1:0] nv_sel_out;
	logic [7:0] rx;
	int         miscompares = 0, checks = 0, ncyc = 0, hi = 0, n = 0;
	int         req_cnt = 0, set_cnt = 0, clr_cnt = 0;
	int         done_dly = 10, done_at = -1, tdone_at = -1;

	always #5 sys_clk = ~sys_clk;

	spwd_top #(.PURST_CYCLES(PUR), .TO_00_CYCLES(T00), .TO_01_CYCLES(T01), .TO_10_CYCLES(T10)) u_dut (
		.sys_clk(sys_clk), .rst(rst), .ce(ce), .pins(pins), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
		.supply_low(supply_low), .trip_program_enable_pin(tpe), .trip_prog_done(trip_done),
		.trip_req(trip_req), .nv_sel_in(nv_sel), .nv_write_done(nv_done), .nv_write_req(nv_req),
		.nv_sel_out(nv_sel_out), .reset_n_out(reset_n_out), .reset_n_oe(reset_n_oe));
	spwd_host u_host (.sys_clk(sys_clk), .pins(pins), .sdo_out(sdo_out), .sdo_oe(sdo_oe));

	task automatic wt(input int c);
		repeat (c) @(posedge sys_clk);
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s exp %0h got %0h", what, exp, got);
		end
	endtask

	task automatic close_out();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ***
	// Store, analog and timeout
	// ***
	always @(posedge sys_clk) begin
		ncyc <= ncyc + 1;
		hi <= pins.sel_n ? hi + 1 : 0;
		nv_done <= (ncyc == done_at);
		trip_done <= (ncyc == tdone_at);
		if (nv_req === 1'b1) begin
			req_cnt <= req_cnt + 1;
			nv_sel <= nv_sel_out;
			done_at <= ncyc + done_dly;
		end
		if (trip_req.set_req === 1'b1 || trip_req.rst_req === 1'b1) begin
			set_cnt <= set_cnt + trip_req.set_req;
			clr_cnt <= clr_cnt + trip_req.rst_req;
			tdone_at <= ncyc + 30;
		end
		if (hi > 10)
			chk("sdo_oe idle", 0, sdo_oe);
		if (ncyc == 40000) begin
			miscompares++;
			close_out();
		end
	end

	// ***
	// Sequence
	// ***
	initial begin
		wt(10);
		chk("reset pin", 1, reset_n_oe);
		chk("sdo_oe", 0, sdo_oe);
		chk("reset data", 0, reset_n_out);
		rst <= 1'b0;
		wt(PUR / 2);
		chk("por hold", 1, reset_n_oe);
		wt(PUR);
		chk("por release", 0, reset_n_oe);
		u_host.xfer(24'h0500, 16, rx);
		chk("read kept", 8'h08, rx);
		foreach (rows[r]) begin
			n = req_cnt;
			u_host.xfer(24'h06, 8, rx);
			u_host.xfer({8'h01, 3'h0, rows[r].sel, 3'h0}, 16, rx);
			wt(20);
			chk("write req", n + 1, req_cnt);
			chk("stored sel", rows[r].sel, nv_sel);
			u_host.xfer(24'h0500, 16, rx);
			chk("read sel", rows[r].rd, rx);
			u_host.kick();
			n = 0;
			while (reset_n_oe !== 1'b1 && n < 3100) begin
				wt(1);
				n++;
			end
			if (rows[r].lim == 0)
				chk("wd off", 0, reset_n_oe);
			else
				chk("wd time", 1, n + 17 >= rows[r].lim && n + 17 <= rows[r].lim + 12);
			for (int k = 0; k < 30 && reset_n_oe !== 1'b0; k++)
				u_host.kick();
		end
		n = req_cnt;
		u_host.xfer(24'h0118, 16, rx);
		u_host.xfer(24'h06, 8, rx);
		u_host.xfer(24'h04, 8, rx);
		u_host.xfer(24'h0118, 16, rx);
		u_host.xfer(24'h06, 8, rx);
		u_host.xfer(24'h0230, 17, rx);
		wt(20);
		chk("refused writes", n, req_cnt);
		done_dly = 600;
		u_host.xfer(24'h0118, 16, rx);
		u_host.xfer(24'h0500, 16, rx);
		chk("busy read", 8'hFF, rx);
		chk("late write", n + 1, req_cnt);
		wt(600);
		u_host.stall_bit = 11;
		u_host.xfer(24'h0500, 16, rx);
		chk("stalled read", 8'h18, rx);
		u_host.stall_bit = -1;
		tpe <= 1'b1;
		u_host.xfer(24'h030001, 24, rx);
		u_host.xfer(24'h020001, 24, rx);
		u_host.xfer(24'h030001, 24, rx);
		u_host.xfer(24'h020003, 24, rx);
		wt(40);
		tpe <= 1'b0;
		u_host.xfer(24'h030001, 24, rx);
		u_host.xfer(24'h020001, 24, rx);
		wt(40);
		chk("trip set", 1, set_cnt);
		chk("trip reset", 1, clr_cnt);
		u_host.idle_clocks();
		u_host.xfer(24'h0500, 16, rx);
		chk("read after idle", 8'h18, rx);
		ce <= 1'b0;
		supply_low <= 1'b1;
		wt(5);
		chk("ce freeze", 0, reset_n_oe);
		ce <= 1'b1;
		wt(5);
		chk("low supply", 1, reset_n_oe);
		supply_low <= 1'b0;
		wt(PUR / 2);
		chk("low hold", 1, reset_n_oe);
		wt(PUR);
		chk("low release", 0, reset_n_oe);
		rst <= 1'b1;
		wt(3);
		rst <= 1'b0;
		wt(PUR + 20);
		u_host.xfer(24'h0500, 16, rx);
		chk("read after reset", 8'h18, rx);
		close_out();
	end
endmodule // spi_watchdog_supervisor_tb
